// [rtl/dbfs_cfg.svh]
// Purpose: timing and reset constants for the dual block flash mode control
// Assumes: mclk at 100 MHz
// Notes:   counts derive from times in their own units
`ifndef DBFS_CFG_SVH
`define DBFS_CFG_SVH
`define DBFS_CLK_MHZ          100
`define DBFS_CB_MAX_US        1000
`define DBFS_CB_MAX_CYC       (`DBFS_CB_MAX_US * `DBFS_CLK_MHZ)
`define DBFS_RESET_VECTOR     16'h0000
`define DBFS_SWAP_RST         1'b0
`define DBFS_SWAP_LOCK_RST    1'b0
`define DBFS_PULSE_CNT_W      4
`endif

// [rtl/dbfs_ctrl.sv]
// Purpose: mode select, block mapping and callback pacing of a dual block
//          flash with self-programming
// Assumes: vpp_high is a comparator output that is high at programming level
// Notes:   swap state and its lock are held as if non-volatile; reset keeps both
`timescale 1ns/100ps
`include "dbfs_cfg.svh"
module dbfs_ctrl import dbfs_pkg::*; #(
	parameter int CB_MAX_CYC = `DBFS_CB_MAX_CYC
) (
	// clock and reset
	input  wire logic      mclk,
	input  wire logic      sys_rst,
	// pins
	input  wire logic      vpp_high,
	// self-programming firmware side
	input  wire dbfs_req_t req,
	input  wire logic      req_valid,
	input  wire logic      op_busy,
	input  wire logic      sp_done,
	output dbfs_ans_t      ans,
	// mapping and status
	output dbfs_mode_t     mode,
	output logic           upper_is_rom,
	output logic           swapped,
	output logic [15:0]    fetch_addr,
	output logic           fetch_start,
	output logic [`DBFS_PULSE_CNT_W-1:0] if_sel,
	output logic           realtime_support_callback
);
	if (CB_MAX_CYC < 2) begin : g_bad_cb
		$error("CB_MAX_CYC too small");
	end

	// swap state is not cleared by sys_rst so the mapping survives reset;
	// a real part keeps it in flash, here a power-on value stands in
	logic       vpp_s;
	logic       vpp_prev_q;
	logic       rst_prev_q;
	logic       swap_q      = `DBFS_SWAP_RST;
	logic       swap_lock_q = `DBFS_SWAP_LOCK_RST;
	logic [31:0] cb_cnt_q;
	logic       release_w;
	logic       vpp_rise_w;

	dbfs_sync u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.din     (vpp_high),
		.dout    (vpp_s)
	);

	// the synchroniser clears on reset and needs two edges to show the pin;
	// release_w fires only once its output holds the real strap level
	logic [2:0] rel_pipe_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rel_pipe_q <= 3'b000;
			rst_prev_q <= 1'b1;
		end else begin
			rel_pipe_q <= {rel_pipe_q[1:0], 1'b1};
			rst_prev_q <= 1'b0;
		end
	end
	assign release_w  = rel_pipe_q == 3'b011;
	assign vpp_rise_w = vpp_s & ~vpp_prev_q;

	always_ff @(posedge mclk) begin
		if (sys_rst)
			vpp_prev_q <= 1'b0;
		else
			vpp_prev_q <= vpp_s;
	end

	// mode control
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode        <= DBFS_MODE_NORMAL;
			fetch_start <= 1'b0;
			fetch_addr  <= `DBFS_RESET_VECTOR;
		end else begin
			fetch_start <= 1'b0;
			if (release_w) begin
				if (vpp_s) begin
					mode <= DBFS_MODE_EXTPROG;
				end else begin
					mode        <= DBFS_MODE_NORMAL;
					fetch_addr  <= `DBFS_RESET_VECTOR;
					fetch_start <= 1'b1;
				end
			end else if (mode == DBFS_MODE_NORMAL && vpp_rise_w
			             && rel_pipe_q == 3'b111) begin
				mode <= DBFS_MODE_SELFPROG;
			end else if (mode == DBFS_MODE_SELFPROG && sp_done) begin
				mode <= DBFS_MODE_NORMAL;
			end
		end
	end

	// hidden rom overlay follows self-programming mode
	always_ff @(posedge mclk) begin
		if (sys_rst)
			upper_is_rom <= 1'b0;
		else if (mode == DBFS_MODE_SELFPROG && sp_done)
			upper_is_rom <= 1'b0;
		else if (mode == DBFS_MODE_NORMAL && vpp_rise_w && !release_w
		         && rel_pipe_q == 3'b111)
			upper_is_rom <= 1'b1;
	end

	// interface select: count pin pulses while in external mode
	always_ff @(posedge mclk) begin
		if (sys_rst)
			if_sel <= '0;
		else if (mode == DBFS_MODE_EXTPROG && vpp_s && !vpp_prev_q
		         && !release_w && if_sel != '1)
			if_sel <= if_sel + 1'b1;
	end

	assign swapped = swap_q;

	// no request is taken while reset is asserted, so the kept state is safe
	logic sp_op_w;
	assign sp_op_w = req_valid && mode == DBFS_MODE_SELFPROG && !sys_rst;

	always_ff @(posedge mclk) begin
		if (sp_op_w && req.op == DBFS_OP_SWAP && !swap_lock_q) begin
			swap_q      <= ~swap_q;
			swap_lock_q <= 1'b1;
		end else if (sp_op_w && req.op == DBFS_OP_ERASE && req.block) begin
			swap_lock_q <= 1'b0;
		end
	end

	// answer to each request, one cycle pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ans <= '0;
		end else begin
			ans <= '0;
			if (sp_op_w) begin
				ans.done <= 1'b1;
				case (req.op)
					DBFS_OP_PROGRAM,
					DBFS_OP_ERASE: begin
						ans.granted <= req.block;
						ans.error   <= ~req.block;
					end
					DBFS_OP_SWAP: begin
						ans.granted <= ~swap_lock_q;
						ans.error   <= swap_lock_q;
					end
					default: begin
						ans.error <= 1'b1;
					end
				endcase
			end else if (req_valid) begin
				ans.done  <= 1'b1;
				ans.error <= 1'b1;
			end
		end
	end

	// callback pacing: request one cycle inside the limit, one cycle pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cb_cnt_q                  <= '0;
			realtime_support_callback <= 1'b0;
		end else begin
			realtime_support_callback <= 1'b0;
			if (mode != DBFS_MODE_SELFPROG || !op_busy) begin
				cb_cnt_q <= '0;
			end else if (cb_cnt_q >= 32'(CB_MAX_CYC - 2)) begin
				cb_cnt_q                  <= '0;
				realtime_support_callback <= 1'b1;
			end else begin
				cb_cnt_q <= cb_cnt_q + 32'd1;
			end
		end
	end

	// gap between callbacks, for checking only
	logic [31:0] gap_q;
	always_ff @(posedge mclk) begin
		if (sys_rst || realtime_support_callback || !op_busy
		    || mode != DBFS_MODE_SELFPROG)
			gap_q <= '0;
		else
			gap_q <= gap_q + 32'd1;
	end

	sequence s_pin_rise;
		mode == DBFS_MODE_NORMAL && vpp_rise_w && rel_pipe_q == 3'b111;
	endsequence
	sequence s_sp_entered;
		mode == DBFS_MODE_SELFPROG && upper_is_rom;
	endsequence

	property p_ext_at_release;
		@(posedge mclk) disable iff (sys_rst)
		release_w && vpp_s |=> mode == DBFS_MODE_EXTPROG;
	endproperty
	a_ext_at_release: assert property (p_ext_at_release)
		else $error("external mode not taken at release");

	property p_normal_at_release;
		@(posedge mclk) disable iff (sys_rst)
		release_w && !vpp_s |=> mode == DBFS_MODE_NORMAL && fetch_start
			&& fetch_addr == 16'h0000;
	endproperty
	a_normal_at_release: assert property (p_normal_at_release)
		else $error("normal start not taken");

	property p_sp_entry;
		@(posedge mclk) disable iff (sys_rst)
		s_pin_rise |=> s_sp_entered;
	endproperty
	a_sp_entry: assert property (p_sp_entry)
		else $error("self-programming entry missed");

	property p_sp_only_from_normal;
		@(posedge mclk) disable iff (sys_rst)
		$rose(mode == DBFS_MODE_SELFPROG) |-> $past(mode) == DBFS_MODE_NORMAL;
	endproperty
	a_sp_only_from_normal: assert property (p_sp_only_from_normal)
		else $error("self-programming entered from wrong mode");

	property p_rom_with_mode;
		@(posedge mclk) disable iff (sys_rst)
		upper_is_rom |-> mode == DBFS_MODE_SELFPROG;
	endproperty
	a_rom_with_mode: assert property (p_rom_with_mode)
		else $error("hidden rom mapped outside self-programming");

	property p_lower_refused;
		@(posedge mclk) disable iff (sys_rst)
		sp_op_w && req.op != DBFS_OP_SWAP && req.op != DBFS_OP_NONE
			&& !req.block |=> ans.error && !ans.granted;
	endproperty
	a_lower_refused: assert property (p_lower_refused)
		else $error("lower block operation not refused");

	property p_swap_toggles;
		@(posedge mclk) disable iff (sys_rst)
		sp_op_w && req.op == DBFS_OP_SWAP && !swap_lock_q
			|=> swapped != $past(swapped) && ans.granted;
	endproperty
	a_swap_toggles: assert property (p_swap_toggles)
		else $error("swap did not exchange blocks");

	property p_second_swap_fails;
		@(posedge mclk) disable iff (sys_rst)
		sp_op_w && req.op == DBFS_OP_SWAP && swap_lock_q
			|=> ans.error && $stable(swapped);
	endproperty
	a_second_swap_fails: assert property (p_second_swap_fails)
		else $error("second swap not refused");

	property p_restore;
		@(posedge mclk) disable iff (sys_rst)
		mode == DBFS_MODE_SELFPROG && sp_done |=>
			mode == DBFS_MODE_NORMAL && !upper_is_rom;
	endproperty
	a_restore: assert property (p_restore)
		else $error("normal mapping not restored");

	property p_cb_gap;
		@(posedge mclk) disable iff (sys_rst)
		gap_q < 32'(CB_MAX_CYC);
	endproperty
	a_cb_gap: assert property (p_cb_gap)
		else $error("callback gap over limit");

	property p_mode_held;
		@(posedge mclk) disable iff (sys_rst)
		mode == DBFS_MODE_EXTPROG |=> mode == DBFS_MODE_EXTPROG;
	endproperty
	a_mode_held: assert property (p_mode_held)
		else $error("external mode left without reset");
endmodule : dbfs_ctrl

// [rtl/dbfs_pkg.sv]
// Purpose: types for the dual block flash mode control
// Assumes: nothing
// Notes:   mode enum and request/answer carriers
package dbfs_pkg;
	typedef enum logic [1:0] {
		DBFS_MODE_NORMAL,
		DBFS_MODE_EXTPROG,
		DBFS_MODE_SELFPROG
	} dbfs_mode_t;

	typedef enum logic [1:0] {
		DBFS_OP_NONE,
		DBFS_OP_PROGRAM,
		DBFS_OP_ERASE,
		DBFS_OP_SWAP
	} dbfs_op_t;

	typedef struct packed {
		dbfs_op_t op;
		logic     block;
	} dbfs_req_t;

	typedef struct packed {
		logic done;
		logic granted;
		logic error;
	} dbfs_ans_t;
endpackage : dbfs_pkg

// [rtl/dbfs_sync.sv]
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to mclk
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module dbfs_sync (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// level
	input  wire logic din,
	output logic      dout
);
	logic meta_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : dbfs_sync

// [verification/dbfs_tool.sv]
// Purpose: external programming tool driving the voltage pin
// Assumes: bench sets hv, then pulses go for one cycle
// Notes:   pulses drop the pin for 4 cycles, then raise it for 4
`timescale 1ns/100ps
module dbfs_tool (
	// clock
	input  wire logic       mclk,
	// commands
	input  wire logic       hv,
	input  wire logic [3:0] npulse,
	input  wire logic       go,
	// pin and status
	output logic            vpp_high,
	output logic            busy
);
	logic [3:0] n_q = 4'h0;
	logic [2:0] t_q = 3'h0;

	always_ff @(posedge mclk) begin
		if (go && n_q == 4'h0) begin
			n_q <= npulse;
			t_q <= 3'h0;
		end else if (n_q != 4'h0) begin
			t_q <= t_q + 3'h1;
			if (t_q == 3'h7)
				n_q <= n_q - 4'h1;
		end
	end

	// each pulse ends with a rise back to the programming level
	assign vpp_high = hv & ~(busy & ~t_q[2]);
	assign busy     = (n_q != 4'h0);
endmodule : dbfs_tool

// [verification/test_dual_block_flash_self_program.sv]
// Purpose: self-checking bench of the flash mode control
// Assumes: callback spacing shortened to 20 cycles
// Notes:   swap state carries across the resets of this run
`timescale 1ns/100ps
module test_dual_block_flash_self_program;
	import dbfs_pkg::*;
	localparam int CBC = 20;
	logic       mclk, sys_rst, hv, go, vpp, tbusy;
	logic       req_valid, op_busy, sp_done, sw;
	logic [3:0] npulse;
	dbfs_req_t  req;
	dbfs_ans_t  ans;
	dbfs_mode_t mode;
	logic       rom, swapped, fst, cb;
	logic [15:0] faddr;
	logic [3:0] if_sel;
	int         miscompares, check_count, cyc;

	dbfs_tool tool (.mclk(mclk), .hv(hv), .npulse(npulse), .go(go),
		.vpp_high(vpp), .busy(tbusy));
	dbfs_ctrl #(.CB_MAX_CYC(CBC)) uut (.mclk(mclk), .sys_rst(sys_rst),
		.vpp_high(vpp), .req(req), .req_valid(req_valid),
		.op_busy(op_busy), .sp_done(sp_done), .ans(ans), .mode(mode),
		.upper_is_rom(rom), .swapped(swapped), .fetch_addr(faddr),
		.fetch_start(fst), .if_sel(if_sel),
		.realtime_support_callback(cb));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// fetch_start may pulse anywhere in the wait, so it is collected
	task automatic rst(input logic h, output logic fs);
		fs = 1'b0;
		@(negedge mclk);
		sys_rst = 1'b1;
		hv = h;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (7) begin
			@(negedge mclk);
			fs = fs | fst;
		end
	endtask : rst

	task automatic rq(input dbfs_op_t o, input logic b, input logic g);
		int k;
		req = '{o, b};
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		k = 0;
		while (ans.done !== 1'b1 && k < 4) begin
			@(negedge mclk);
			k++;
		end
		chk("done", 1, ans.done);
		chk("granted", g, ans.granted);
		chk("error", !g, ans.error);
		@(negedge mclk);
	endtask : rq

	task automatic t_ext;
		logic fs;
		rst(1'b1, fs);
		chk("mode", DBFS_MODE_EXTPROG, mode);
		npulse = 4'h3;
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		for (int k = 0; k < 60 && tbusy; k++) @(negedge mclk);
		repeat (6) @(negedge mclk);
		chk("if_sel", 3, if_sel);
		chk("mode", DBFS_MODE_EXTPROG, mode);
		$display("done t_ext");
	endtask : t_ext

	task automatic t_norm;
		logic fs;
		rst(1'b0, fs);
		chk("mode", DBFS_MODE_NORMAL, mode);
		chk("fetch_start", 1, fs);
		chk("fetch_addr", 16'h0000, faddr);
		chk("rom", 0, rom);
		hv = 1'b1;
		for (int k = 0; k < 8 && mode != DBFS_MODE_SELFPROG; k++)
			@(negedge mclk);
		chk("mode", DBFS_MODE_SELFPROG, mode);
		chk("rom", 1, rom);
		$display("done t_norm");
	endtask : t_norm

	task automatic t_ops;
		dbfs_op_t ops [10] = '{DBFS_OP_PROGRAM, DBFS_OP_PROGRAM,
			DBFS_OP_ERASE, DBFS_OP_SWAP, DBFS_OP_SWAP, DBFS_OP_ERASE,
			DBFS_OP_SWAP, DBFS_OP_NONE, DBFS_OP_ERASE, DBFS_OP_SWAP};
		logic [9:0] blk = 10'b1111111010;
		logic [9:0] gr  = 10'b1101101010;
		for (int i = 0; i < 10; i++) begin
			rq(ops[i], blk[i], gr[i]);
			sw = sw ^ (ops[i] == DBFS_OP_SWAP && gr[i]);
			chk("swapped", sw, swapped);
		end
		$display("done t_ops");
	endtask : t_ops

	task automatic t_cb;
		int gap, mx, n;
		gap = 0;
		mx = 0;
		n = 0;
		op_busy = 1'b1;
		repeat (3 * CBC) begin
			@(negedge mclk);
			gap++;
			if (cb === 1'b1) begin
				n++;
				gap = 0;
			end
			if (gap > mx)
				mx = gap;
		end
		op_busy = 1'b0;
		chk("cb_seen", 1, n >= 2);
		chk("cb_gap", 1, mx <= CBC);
		$display("done t_cb");
	endtask : t_cb

	task automatic t_exit;
		logic fs;
		sp_done = 1'b1;
		@(negedge mclk);
		sp_done = 1'b0;
		@(negedge mclk);
		chk("mode", DBFS_MODE_NORMAL, mode);
		chk("rom", 0, rom);
		rq(DBFS_OP_PROGRAM, 1'b1, 1'b0);
		rst(1'b0, fs);
		chk("swapped", sw, swapped);
		$display("done t_exit");
	endtask : t_exit

	// ceiling well above the roughly 150 cycles the tests need
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		sys_rst = 1'b1;
		hv = 1'b0;
		go = 1'b0;
		npulse = 4'h0;
		req = '{DBFS_OP_NONE, 1'b0};
		req_valid = 1'b0;
		op_busy = 1'b0;
		sp_done = 1'b0;
		sw = 1'b0;
		miscompares = 0;
		check_count = 0;
		cyc = 0;
		t_ext();
		t_norm();
		t_ops();
		t_cb();
		t_exit();
		summarize();
	end
endmodule : test_dual_block_flash_self_program
